// [hdl/pmc_pkg.sv]
// shared constants, register map and state encoding of the power controller register bank
package pmc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_DEV_ID   = 8'h00;
  localparam logic [7:0] ADDR_NVM_VER  = 8'h01;
  localparam logic [7:0] ADDR_SW_CTRL  = 8'h02;
  localparam logic [7:0] ADDR_PG_CFG_A = 8'h15;
  localparam logic [7:0] ADDR_PG_CFG_B = 8'h16;
  localparam logic [7:0] ADDR_POWER_GOOD_FAULT_STATUS = 8'h17;
  localparam logic [7:0] ADDR_SW_RESET = 8'h18;
  localparam logic [7:0] ADDR_TOP_STAT = 8'h1D;
  localparam logic [7:0] ADDR_SW_STAT  = 8'h1E;
  localparam logic [7:0] ADDR_LIN_STAT = 8'h1F;
  localparam logic [7:0] ADDR_LOAD_SEL = 8'h24;
  localparam logic [7:0] ADDR_LOAD_HI  = 8'h25;
  localparam logic [7:0] ADDR_LOAD_LO  = 8'h26;

  // event flag and mask registers, entry 0 top_a, 1 top_b, 2 switcher, 3 linear
  localparam logic [3:0][7:0] FLAG_ADDR   = {8'h1C, 8'h1B, 8'h1A, 8'h19};
  localparam logic [3:0][7:0] EVMASK_ADDR = {8'h23, 8'h22, 8'h21, 8'h20};
  localparam logic [3:0][7:0] FLAG_WMASK  = {8'h77, 8'h77, 8'h01, 8'hFF};
  localparam logic [3:0][7:0] EVMASK_WMASK = {8'hDD, 8'hDD, 8'h01, 8'h95};

  // switcher control fields
  localparam int unsigned     CTRL_MP_BIT   = 4;
  localparam int unsigned     CTRL_FPWM_BIT = 3;
  localparam int unsigned     CTRL_RDIS_BIT = 2;
  localparam int unsigned     CTRL_PIN_BIT  = 1;
  localparam int unsigned     CTRL_ON_BIT   = 0;
  localparam logic [7:0]      CTRL_WMASK    = 8'h1F;
  localparam logic [7:0]      CTRL_RESET    = 8'h04;

  // other field layouts and reset values
  localparam logic [5:0]      ID_RSVD_VAL   = 6'h02;
  localparam logic [7:0]      PG_B_WMASK    = 8'h03;
  localparam logic [7:0]      PG_CFG_RESET  = 8'h00;
  localparam logic [7:0]      LOAD_SEL_WMASK = 8'h01;
  localparam logic [7:0]      POWER_GOOD_FAULT_STATUS_MASK = 8'h0F;
  localparam logic [7:0]      TOP_STAT_MASK = 8'h9E;
  localparam logic [7:0]      RAIL_STAT_MASK = 8'hDD;
  localparam int unsigned     SWRST_BIT     = 0;
  localparam int unsigned     RST_FLAG_IDX  = 1;

  // serial interface
  localparam logic [3:0]      BYTE_BITS     = 4'h8;
  localparam logic [6:0]      DEV_ADDR_DEF  = 7'h60;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ADDR  = 4'b0001,
    ST_AACK  = 4'b0010,
    ST_INDEX = 4'b0011,
    ST_IACK  = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WACK  = 4'b0110,
    ST_TX    = 4'b0111,
    ST_MACK  = 4'b1000
  } pmc_ser_st_e;

endpackage : pmc_pkg

// [hdl/pmc_ser_front.sv]
// pin synchronisers and bus condition detector for the serial interface
`timescale 1ns/1ps
module pmc_ser_front (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic en_pin,
  // conditioned outputs
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_lvl,
  output logic      en_lvl
);

  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic [1:0] en_sy_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_rise_nxt;
  logic       scl_fall_nxt;
  logic       start_nxt;
  logic       stop_nxt;

  // only the second stage of each synchroniser is looked at
  always_comb begin
    scl_rise_nxt = scl_sy_r[1] & ~scl_d_r;
    scl_fall_nxt = ~scl_sy_r[1] & scl_d_r;
    start_nxt    = scl_sy_r[1] & scl_d_r & sda_d_r & ~sda_sy_r[1];
    stop_nxt     = scl_sy_r[1] & scl_d_r & ~sda_d_r & sda_sy_r[1];
  end

  // two-stage sync, history and registered condition pulses; bus idles high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_r  <= 2'h3;
      sda_sy_r  <= 2'h3;
      en_sy_r   <= 2'h0;
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      scl_rise  <= 1'b0;
      scl_fall  <= 1'b0;
      start_det <= 1'b0;
      stop_det  <= 1'b0;
      sda_lvl   <= 1'b1;
      en_lvl    <= 1'b0;
    end else begin
      scl_sy_r  <= {scl_sy_r[0], scl_in};
      sda_sy_r  <= {sda_sy_r[0], sda_in};
      en_sy_r   <= {en_sy_r[0], en_pin};
      scl_d_r   <= scl_sy_r[1];
      sda_d_r   <= sda_sy_r[1];
      scl_rise  <= scl_rise_nxt;
      scl_fall  <= scl_fall_nxt;
      start_det <= start_nxt;
      stop_det  <= stop_nxt;
      sda_lvl   <= sda_sy_r[1];
      en_lvl    <= en_sy_r[1];
    end
  end

endmodule : pmc_ser_front

// [hdl/pmc_reg_bank.sv]
// power controller register bank behind a two-wire serial slave
//
// Contract
// - identity register returns read-only part code in bits 7:6; writes ignored.
// - version register returns eight-bit read-only code of configuration memory.
// - multiphase bit 0 gives automatic phase shedding; 1 forces two-phase PWM.
// - force-PWM bit 0 allows automatic PFM/PWM; 1 holds PWM.
// - discharge bit connects resistor while switcher off; resets to one.
// - enable-source bit 0 register only; 1 register bit and pin.
// - register enable bit turns switcher off at 0, on at 1.
// - all registers reached over serial bus, register address then data.
// - index advances after each written byte; reads do not advance.
`timescale 1ns/1ps
module pmc_reg_bank
  import pmc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = DEV_ADDR_DEF,
  parameter logic [7:0] CTRL_INIT = CTRL_RESET,
  parameter int         LOAD_W    = 10
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // serial bus pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // external enable pin
  input  wire logic              en_pin,
  // configuration memory codes
  input  wire logic [1:0]        part_code_field,
  input  wire logic [7:0]        nvm_version_code,
  // event pulses from the rails
  input  wire logic [7:0]        top_event_set,
  input  wire logic [7:0]        switcher_event_set,
  input  wire logic [7:0]        linear_reg_event_set,
  // live status from the rails
  input  wire logic [3:0]        power_good_fault_status_in,
  input  wire logic [7:0]        top_status_in,
  input  wire logic [7:0]        switcher_status_in,
  input  wire logic [7:0]        linear_reg_status_in,
  input  wire logic [LOAD_W-1:0] load_current_in,
  // switcher controls
  output logic                   force_multiphase_pwm,
  output logic                   force_pwm_select,
  output logic                   output_discharge_enable,
  output logic                   switcher_run,
  output logic                   discharge_active,
  // other configuration
  output logic [7:0]             pgood_cfg_a,
  output logic [7:0]             pgood_cfg_b,
  output logic [31:0]            event_mask,
  output logic                   load_meter_sel
);

  // load meter value must fit the two readback bytes
  if (LOAD_W < 9 || LOAD_W > 16) begin : g_chk
    $error("LOAD_W must be 9 to 16");
  end

  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        sda_lvl;
  logic        en_lvl;

  pmc_ser_front u_front (
    .clk       (clk),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .en_pin    (en_pin),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_lvl   (sda_lvl),
    .en_lvl    (en_lvl)
  );

  // serial slave state
  pmc_ser_st_e st_r;
  pmc_ser_st_e st_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic [7:0]  idx_r;
  logic [7:0]  idx_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        rd_r;
  logic        rd_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        wr_stb_r;
  logic        wr_stb_nxt;
  logic [7:0]  wr_idx_r;
  logic [7:0]  wr_dat_r;
  logic [7:0]  rd_data;

  // register storage
  logic [7:0]       ctrl_r;
  logic [7:0]       ctrl_nxt;
  logic [7:0]       pga_r;
  logic [7:0]       pga_nxt;
  logic [7:0]       pgb_r;
  logic [7:0]       pgb_nxt;
  logic [7:0]       sel_r;
  logic [7:0]       sel_nxt;
  logic             swrst_r;
  logic             swrst_nxt;
  logic [3:0][7:0]  flag_r;
  logic [3:0][7:0]  mask_r;
  logic [3:0][7:0]  ev_set;
  logic [15:0]      load_ext;

  // serial slave: byte receive, ack, transmit and master ack
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    idx_nxt    = idx_r;
    oe_nxt     = oe_r;
    rd_nxt     = rd_r;
    nack_nxt   = nack_r;
    wr_stb_nxt = 1'b0;
    if (stop_det) begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      st_nxt  = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_rise && cnt_r != BYTE_BITS) begin
            sh_nxt  = {sh_r[6:0], sda_lvl};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_nxt = 4'h0;
            case (st_r)
              ST_ADDR: begin
                if (sh_r[7:1] == DEV_ADDR) begin
                  rd_nxt = sh_r[0];
                  oe_nxt = 1'b1;
                  st_nxt = ST_AACK;
                end else begin
                  st_nxt = ST_IDLE;              // other slave addressed
                end
              end
              ST_INDEX: begin
                idx_nxt = sh_r;
                oe_nxt  = 1'b1;
                st_nxt  = ST_IACK;
              end
              default: begin
                wr_stb_nxt = 1'b1;
                oe_nxt     = 1'b1;
                st_nxt     = ST_WACK;
              end
            endcase
          end
        end
        ST_AACK, ST_IACK, ST_WACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            if (st_r == ST_AACK && rd_r) begin
              sh_nxt  = rd_data;
              oe_nxt  = ~rd_data[7];
              cnt_nxt = 4'h1;
              st_nxt  = ST_TX;
            end else if (st_r == ST_AACK) begin
              st_nxt = ST_INDEX;
            end else begin
              if (st_r == ST_WACK) begin
                idx_nxt = idx_r + 8'h01;
              end
              st_nxt = ST_WDATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_nxt = 1'b0;
              st_nxt = ST_MACK;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = ~sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nack_nxt = sda_lvl;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_nxt = ST_IDLE;
            end else begin
              sh_nxt  = rd_data;
              oe_nxt  = ~rd_data[7];
              cnt_nxt = 4'h1;
              st_nxt  = ST_TX;
            end
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // serial slave registers; sda_out stays low, only the enable moves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= ST_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      idx_r    <= 8'h00;
      oe_r     <= 1'b0;
      rd_r     <= 1'b0;
      nack_r   <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wr_dat_r <= 8'h00;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      idx_r    <= idx_nxt;
      oe_r     <= oe_nxt;
      rd_r     <= rd_nxt;
      nack_r   <= nack_nxt;
      wr_stb_r <= wr_stb_nxt;
      wr_idx_r <= idx_r;
      wr_dat_r <= sh_r;
      sda_out  <= 1'b0;
      sda_oe   <= oe_nxt;
    end
  end

  // read multiplexer; unmapped addresses and masked bits read zero, identity bits 5:0 read ID_RSVD_VAL
  always_comb begin
    load_ext = 16'(load_current_in);
    rd_data  = 8'h00;
    case (idx_r)
      ADDR_DEV_ID:   rd_data = {part_code_field, ID_RSVD_VAL};
      ADDR_NVM_VER:  rd_data = nvm_version_code;
      ADDR_SW_CTRL:  rd_data = ctrl_r;
      ADDR_PG_CFG_A: rd_data = pga_r;
      ADDR_PG_CFG_B: rd_data = pgb_r;
      ADDR_POWER_GOOD_FAULT_STATUS: rd_data = {4'h0, power_good_fault_status_in} & POWER_GOOD_FAULT_STATUS_MASK;
      ADDR_SW_RESET: rd_data = 8'h00;
      ADDR_TOP_STAT: rd_data = top_status_in & TOP_STAT_MASK;
      ADDR_SW_STAT:  rd_data = switcher_status_in & RAIL_STAT_MASK;
      ADDR_LIN_STAT: rd_data = linear_reg_status_in & RAIL_STAT_MASK;
      ADDR_LOAD_SEL: rd_data = sel_r;
      ADDR_LOAD_HI:  rd_data = load_ext[15:8];
      ADDR_LOAD_LO:  rd_data = load_ext[7:0];
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (idx_r == FLAG_ADDR[i]) begin
            rd_data = flag_r[i];
          end
          if (idx_r == EVMASK_ADDR[i]) begin
            rd_data = mask_r[i];
          end
        end
      end
    endcase
  end

  // plain read-write registers and the self-clearing software reset
  always_comb begin
    ctrl_nxt  = ctrl_r;
    pga_nxt   = pga_r;
    pgb_nxt   = pgb_r;
    sel_nxt   = sel_r;
    swrst_nxt = 1'b0;
    if (swrst_r) begin
      ctrl_nxt = CTRL_INIT & CTRL_WMASK;
      pga_nxt  = PG_CFG_RESET;
      pgb_nxt  = PG_CFG_RESET;
      sel_nxt  = 8'h00;
    end else if (wr_stb_r) begin
      case (wr_idx_r)
        ADDR_SW_CTRL:  ctrl_nxt  = wr_dat_r & CTRL_WMASK;
        ADDR_PG_CFG_A: pga_nxt   = wr_dat_r;
        ADDR_PG_CFG_B: pgb_nxt   = wr_dat_r & PG_B_WMASK;
        ADDR_LOAD_SEL: sel_nxt   = wr_dat_r & LOAD_SEL_WMASK;
        ADDR_SW_RESET: swrst_nxt = wr_dat_r[SWRST_BIT];
        default:       ctrl_nxt  = ctrl_r;        // read-only, unmapped, or flag and mask registers written below
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_INIT & CTRL_WMASK;
      pga_r   <= PG_CFG_RESET;
      pgb_r   <= PG_CFG_RESET;
      sel_r   <= 8'h00;
      swrst_r <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      pga_r   <= pga_nxt;
      pgb_r   <= pgb_nxt;
      sel_r   <= sel_nxt;
      swrst_r <= swrst_nxt;
    end
  end

  // event sources; the software reset reports itself in top_b
  always_comb begin
    ev_set               = '0;
    ev_set[0]            = top_event_set;
    ev_set[RST_FLAG_IDX] = {7'h00, swrst_r};
    ev_set[2]            = switcher_event_set;
    ev_set[3]            = linear_reg_event_set;
  end

  // sticky flags with write-one-to-clear, set beats clear; masks plain
  for (genvar g = 0; g < 4; g++) begin : g_ev
    logic [7:0] clr;
    logic [7:0] flag_nxt;
    logic [7:0] mask_nxt;
    always_comb begin
      clr      = (wr_stb_r && wr_idx_r == FLAG_ADDR[g]) ? wr_dat_r : 8'h00;
      flag_nxt = ((flag_r[g] & ~clr) | ev_set[g]) & FLAG_WMASK[g];
      mask_nxt = mask_r[g];
      if (swrst_r) begin
        mask_nxt = 8'h00;
      end else if (wr_stb_r && wr_idx_r == EVMASK_ADDR[g]) begin
        mask_nxt = wr_dat_r & EVMASK_WMASK[g];
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_r[g] <= 8'h00;
        mask_r[g] <= 8'h00;
      end else begin
        flag_r[g] <= flag_nxt;
        mask_r[g] <= mask_nxt;
      end
    end
  end

  // switcher control and other configuration outputs, registered from the register bytes and pin
  logic run_nxt;
  logic dis_nxt;
  always_comb begin
    run_nxt = ctrl_r[CTRL_ON_BIT] & (~ctrl_r[CTRL_PIN_BIT] | en_lvl);
    dis_nxt = ctrl_r[CTRL_RDIS_BIT] & ~switcher_run;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      force_multiphase_pwm    <= 1'b0;
      force_pwm_select        <= 1'b0;
      output_discharge_enable <= 1'b0;
      switcher_run            <= 1'b0;
      discharge_active        <= 1'b0;
      pgood_cfg_a             <= 8'h00;
      pgood_cfg_b             <= 8'h00;
      event_mask              <= 32'h0000_0000;
      load_meter_sel          <= 1'b0;
    end else begin
      force_multiphase_pwm    <= ctrl_r[CTRL_MP_BIT];
      force_pwm_select        <= ctrl_r[CTRL_FPWM_BIT];
      output_discharge_enable <= ctrl_r[CTRL_RDIS_BIT];
      switcher_run            <= run_nxt;
      discharge_active        <= dis_nxt;
      pgood_cfg_a             <= pga_r;
      pgood_cfg_b             <= pgb_r;
      event_mask              <= mask_r;
      load_meter_sel          <= sel_r[0];
    end
  end

endmodule : pmc_reg_bank

// [bench/pmc_host.sv]
// serial bus host model: start, stop, byte transfers, register accesses
`timescale 1ns/1ps
module pmc_host
  import pmc_pkg::*;
(
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_h
);
  // clocks per quarter bit
  localparam int Q = 5;
  // bus idle, both lines released
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // start, also a repeated start when entered with clock low
  task automatic start();
    w(Q);
    sda_h <= 1'b1;
    w(Q);
    scl <= 1'b1;
    w(2*Q);
    sda_h <= 1'b0;
    w(2*Q);
    scl <= 1'b0;
  endtask : start
  // stop, then the bus rests
  task automatic stop();
    w(Q);
    sda_h <= 1'b0;
    w(Q);
    scl <= 1'b1;
    w(2*Q);
    sda_h <= 1'b1;
    w(4*Q);
  endtask : stop
  // data moves only mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    w(Q);
    sda_h <= b;
    w(Q);
    scl <= 1'b1;
    w(Q);
    r = sda_in;
    w(Q);
    scl <= 1'b0;
  endtask : bit_io
  // eight bits msb first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                         output logic ar);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ab, ar);
  endtask : byte_io
  // index then one or two data bytes in one transfer
  task automatic wr(input logic [7:0] idx, d0, d1, input int n, output logic ok);
    logic [7:0] rx;
    logic [3:0] a;
    a = 4'h0;
    start();
    byte_io({DEV_ADDR_DEF, 1'b0}, 1'b1, rx, a[0]);
    byte_io(idx, 1'b1, rx, a[1]);
    byte_io(d0, 1'b1, rx, a[2]);
    if (n > 1)
      byte_io(d1, 1'b1, rx, a[3]);
    stop();
    ok = (a == 4'h0);
  endtask : wr
  // index, repeated start, two bytes of the same register
  task automatic rd(input logic [7:0] idx, output logic [7:0] r0, r1, output logic ok);
    logic [2:0] a;
    logic       x;
    start();
    byte_io({DEV_ADDR_DEF, 1'b0}, 1'b1, r0, a[0]);
    byte_io(idx, 1'b1, r0, a[1]);
    start();
    byte_io({DEV_ADDR_DEF, 1'b1}, 1'b1, r0, a[2]);
    byte_io(8'hFF, 1'b0, r0, x);
    byte_io(8'hFF, 1'b1, r1, x);
    stop();
    ok = (a == 3'h0);
  endtask : rd
endmodule : pmc_host

// [bench/pmc_reg_bank_assertions.sv]
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module pmc_reg_bank_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic scl_in,
  input wire logic en_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  // switcher controls
  input wire logic force_multiphase_pwm,
  input wire logic force_pwm_select,
  input wire logic output_discharge_enable,
  input wire logic switcher_run,
  input wire logic discharge_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // switcher on for two samples
  sequence s_run2;
    switcher_run && $past(switcher_run);
  endsequence
  // switcher off with discharge selected for two samples
  sequence s_off2;
    !switcher_run && !$past(switcher_run) && output_discharge_enable
      && $past(output_discharge_enable);
  endsequence
  a_discharge_off_run: assert property (s_run2 |-> !discharge_active)
    else $error("discharge active while switcher runs");
  a_discharge_on_off: assert property (s_off2 |-> discharge_active)
    else $error("discharge missing while switcher off");
  a_reset_discharge: assert property ($rose(rst_n) |-> !switcher_run ##1 output_discharge_enable)
    else $error("discharge bit not set after reset");
  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data enable moved while clock high");
  a_oe_after_fall: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 4))
    else $error("data enable rose too soon after clock fall");
  a_mode_when_low: assert property ($changed(force_pwm_select) || $changed(force_multiphase_pwm)
    |-> !scl_in)
    else $error("mode output changed outside a write");
  a_run_rise_cause: assert property ($rose(switcher_run) |-> !scl_in || $past(en_pin, 2))
    else $error("switcher started without write or pin");
endmodule : pmc_reg_bank_assertions

bind pmc_reg_bank pmc_reg_bank_assertions u_chk (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .en_pin(en_pin), .sda_out(sda_out),
  .sda_oe(sda_oe), .force_multiphase_pwm(force_multiphase_pwm),
  .force_pwm_select(force_pwm_select), .output_discharge_enable(output_discharge_enable),
  .switcher_run(switcher_run), .discharge_active(discharge_active)
);

// [bench/test_pmc_reg_bank.sv]
// self-checking bench: register bank reached through the host model
`timescale 1ns/1ps
module test_pmc_reg_bank;
  import pmc_pkg::*;
  localparam logic [1:0] PART = 2'h2;  // arbitrary part code
  localparam logic [7:0] NVM  = 8'h5A; // arbitrary version code
  localparam logic [7:0] ST   = 8'hB7;
  logic       clk, rst_n, en_pin, scl, sda_h, sda_w, sda_out, sda_oe;
  logic       fmp, fpwm, odis, run, dact, lsel;
  logic [7:0] ev, st, pga, pgb;
  logic [31:0] emask;
  logic [9:0] ld;
  int         miscompares, checks;
  // map after reset and one event pulse
  logic [7:0] ta [14] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h15, 8'h17, 8'h19, 8'h1A,
                          8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h25, 8'h26};
  logic [7:0] te [14] = '{{PART, 6'h02}, NVM, 8'h04, 8'h00, 8'h00, ST & 8'h0F, 8'hFF,
                          8'h00, 8'h77, 8'h77, ST & 8'h9E, ST & 8'hDD, 8'h02, 8'hC9};
  logic [7:0] cv [5] = '{8'h10, 8'h08, 8'h04, 8'h00, 8'hFF};
  // control value, pin, run, discharge active
  logic [6:0] rt [5] = '{{4'h1, 3'b010}, {4'h5, 3'b010}, {4'h7, 3'b001}, {4'h2, 3'b100},
                         {4'h3, 3'b110}};
  // open-drain data line with pull-up
  assign sda_w = sda_h & ~(sda_oe & ~sda_out);
  pmc_host host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_h(sda_h));
  pmc_reg_bank DUT (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .en_pin(en_pin), .part_code_field(PART), .nvm_version_code(NVM),
    .top_event_set(ev), .switcher_event_set(ev), .linear_reg_event_set(ev),
    .power_good_fault_status_in(st[3:0]), .top_status_in(st), .switcher_status_in(st),
    .linear_reg_status_in(st), .load_current_in(ld), .force_multiphase_pwm(fmp),
    .force_pwm_select(fpwm), .output_discharge_enable(odis), .switcher_run(run),
    .discharge_active(dact), .pgood_cfg_a(pga), .pgood_cfg_b(pgb), .event_mask(emask),
    .load_meter_sel(lsel)
  );
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d0, d1, input int n);
    logic ok;
    host.wr(a, d0, d1, n, ok);
    chk("write ack", ok, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] r0, r1;
    logic       ok;
    host.rd(a, r0, r1, ok);
    chk("read ack", ok, 1'b1);
    chk($sformatf("reg %h", a), r0, e);
    chk($sformatf("reg %h again", a), r1, e);
  endtask : rd
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    en_pin = 1'b0;
    ev = 8'h00;
    st = ST;
    ld = 10'h2C9;
    miscompares = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("discharge", odis, 1'b1);
    chk("run", run, 1'b0);
    ev <= 8'hFF;
    @(posedge clk);
    ev <= 8'h00;
    foreach (ta[i]) rd(ta[i], te[i]);
    $display("test reset map done");
    wr(8'h00, 8'hFF, 8'hFF, 2);
    rd(8'h00, {PART, 6'h02});
    rd(8'h01, NVM);
    wr(8'h1B, 8'h77, 8'h77, 2);
    rd(8'h1B, 8'h00);
    rd(8'h1C, 8'h00);
    rd(8'h19, 8'hFF);
    rd(8'h1F, ST & 8'hDD);
    $display("test read-only and flags done");
    foreach (cv[i]) begin
      wr(ADDR_SW_CTRL, cv[i], 8'h00, 1);
      chk("multiphase", fmp, cv[i][4]);
      chk("force pwm", fpwm, cv[i][3]);
      chk("discharge", odis, cv[i][2]);
      rd(ADDR_SW_CTRL, cv[i] & CTRL_WMASK);
    end
    $display("test control fields done");
    foreach (rt[i]) begin
      en_pin <= rt[i][2];
      wr(ADDR_SW_CTRL, {4'h0, rt[i][6:3]}, 8'h00, 1);
      repeat (2) @(posedge clk);
      chk("run", run, rt[i][1]);
      chk("discharge active", dact, rt[i][0]);
    end
    en_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk("run", run, 1'b0);
    en_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk("run", run, 1'b1);
    $display("test enable source done");
    wr(ADDR_PG_CFG_A, 8'hA5, 8'hFF, 2);
    chk("pgood a", pga, 8'hA5);
    chk("pgood b", pgb, 8'h03);
    rd(ADDR_PG_CFG_A, 8'hA5);
    wr(8'h20, 8'hFF, 8'hFF, 2);
    wr(8'h22, 8'hFF, 8'hFF, 2);
    wr(ADDR_LOAD_SEL, 8'hFF, 8'h00, 1);
    chk("event mask", emask, 32'hDDDD_0195);
    chk("load select", lsel, 1'b1);
    rd(ADDR_LOAD_SEL, 8'h01);
    wr(ADDR_SW_RESET, 8'h01, 8'h00, 1);
    rd(ADDR_SW_CTRL, CTRL_RESET);
    rd(8'h1A, 8'h01);
    rd(ADDR_SW_RESET, 8'h00);
    chk("pgood a", pga, 8'h00);
    chk("event mask", emask, 32'h0000_0000);
    chk("load select", lsel, 1'b0);
    $display("test software reset done");
    finish_test();
  end
endmodule : test_pmc_reg_bank
